// ---- src/asp_pkg.sv ----
// Purpose: constants and carrier types for the audio serial port array
// Assumes: word-addressed register bus, one 32-bit register per address
// Notes: reset of every register is zero unless a reset constant says otherwise
package asp_pkg;
  localparam int NPORT = 6;
  localparam int NLINE = 12;
  localparam int NPIN = 20;
  localparam int AW = 16;
  // register word offsets
  localparam logic [6:0] OFS_CTL = 7'h00;
  localparam logic [6:0] OFS_DIV = 7'h08;
  localparam logic [6:0] OFS_DMA = 7'h10;
  localparam logic [6:0] OFS_ROUTE = 7'h20;
  localparam logic [6:0] OFS_PULL = 7'h38;
  localparam logic [6:0] OFS_GEN = 7'h39;
  localparam logic [6:0] OFS_STAT = 7'h3a;
  localparam logic [6:0] OFS_INSEL = 7'h40;
  // port control fields
  localparam int CTL_EN = 0;
  localparam int CTL_MODE = 1;
  localparam int CTL_LSBF = 3;
  localparam int CTL_WLEN = 4;
  localparam int CTL_CKI = 9;
  localparam int CTL_FSI = 10;
  localparam int CTL_DIR = 11;
  localparam int CTL_CMP = 13;
  localparam int CTL_ALAW = 15;
  localparam int CTL_PAIR = 16;
  localparam int CTL_SLOT = 17;
  // divider, input select, route, generator and status fields
  localparam int DV_HALF = 0;
  localparam int DV_FRM = 8;
  localparam int IN_CK = 0;
  localparam int IN_FS = 5;
  localparam int IN_D = 10;
  localparam int RT_SIG = 0;
  localparam int RT_OE = 5;
  localparam int GN_HALF = 0;
  localparam int GN_FRM = 16;
  localparam int ST_ERR = 0;
  localparam int ST_BUSY = 12;
  localparam int ST_FULL = 18;
  localparam logic [4:0] SEL_GCK = 5'h14;
  localparam logic [4:0] SEL_GFS = 5'h15;
  localparam logic [7:0] DIV_MIN = 8'h02;
  localparam logic [5:0] WL_MIN = 6'h03;
  localparam logic [5:0] WL_MIN_LR = 6'h08;
  localparam logic [NPIN-1:0] PULL_RST = 20'hfffff;

  typedef enum logic [1:0] {MODE_STD, MODE_TDM, MODE_I2S, MODE_LJ} asp_mode_type;

  typedef struct packed {
    logic [7:0] div;
    logic ck;
    logic fs;
    logic [7:0] fcnt;
    logic ckp;
    logic fsp;
    logic arm;
    logic [5:0] bits;
    logic [6:0] slot;
    logic [1:0] txd;
    logic [1:0][31:0] tsh;
    logic [1:0][31:0] rsh;
  } asp_port_type;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0] data;
    logic full;
    logic err;
  } asp_line_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] sel;
  } asp_mem_type;

  typedef struct packed {
    asp_port_type [NPORT-1:0] port;
    asp_line_type [NLINE-1:0] line;
    logic [NPORT-1:0][31:0] ctl;
    logic [NPORT-1:0][15:0] div;
    logic [NPORT-1:0][19:0] insel;
    logic [NPIN-1:0][9:0] route;
    logic [NPIN-1:0] pull;
    logic [31:0] gen;
    logic gtog;
    logic [NPIN-1:0] ps1;
    logic [NPIN-1:0] ps2;
    logic [1:0] gs1;
    logic [1:0] gs2;
    asp_mem_type mem;
    logic wrq;
    logic [31:0] rdata;
    logic [NPIN-1:0] pout;
    logic [NPIN-1:0] poe_n;
  } asp_sys_type;

  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic [31:0] cfg;
    logic [15:0] cnt;
    logic [15:0] fcnt;
    logic ck;
    logic fs;
  } asp_link_type;
endpackage

// ---- src/asp_top.sv ----
// Purpose: six audio serial ports, pin routing matrix, pull-ups, dma
// Assumes: Avalon-MM slave with word addresses; memory port on core clock
// Notes: serial clocks above a quarter of the core clock are not sampled
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module asp_top (
  input wire logic CLK_SYS_IN, // core clock
  input wire logic CLK_LINK_IN, // audio master clock for generator
  input wire logic RESETN_IN, // async reset, active low
  input wire logic [6:0] AVS_ADDRESS_IN, // word address
  input wire logic AVS_READ_IN, // read request
  input wire logic AVS_WRITE_IN, // write request
  input wire logic [31:0] AVS_WRITEDATA_IN, // write data
  input wire logic [3:0] AVS_BYTEENABLE_IN, // byte lanes
  output logic [31:0] AVS_READDATA_OUT, // read data
  output logic AVS_WAITREQUEST_OUT, // stall
  input wire logic [asp_pkg::NPIN-1:0] APP_PINS_IN, // pin levels
  output logic [asp_pkg::NPIN-1:0] APP_PINS_OUT, // pin drive value
  output logic [asp_pkg::NPIN-1:0] APP_PINS_OE_N_OUT, // low drives pin
  output logic [asp_pkg::NPIN-1:0] PIN_PULLUP_EN_OUT, // pull-up enable
  output logic MEM_REQ_OUT, // dma request
  output logic MEM_WE_OUT, // dma write
  output logic [asp_pkg::AW-1:0] MEM_ADDR_OUT, // dma word address
  output logic [31:0] MEM_WDATA_OUT, // dma write data
  input wire logic MEM_ACK_IN, // dma done
  input wire logic [31:0] MEM_RDATA_IN // dma read data
);
  import asp_pkg::*;

  asp_sys_type s;
  asp_sys_type n;
  asp_link_type l;
  asp_link_type ln;

  function automatic logic f_pick(input logic [4:0] sel, input logic [NPIN-1:0] pins,
                                  input logic [1:0] g);
    logic v;
    v = 1'b0;
    if (sel < 5'(NPIN)) v = pins[sel];
    else if (sel == SEL_GCK) v = g[0];
    else if (sel == SEL_GFS) v = g[1];
    return v;
  endfunction

  function automatic logic [31:0] f_be(input logic [31:0] o, input logic [31:0] w,
                                       input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) o[8*i +: 8] = w[8*i +: 8];
    end
    return o;
  endfunction

  // segment encoder shared by both laws
  function automatic logic [7:0] f_cmp(input logic [15:0] x, input logic alaw);
    logic [15:0] m;
    logic [2:0] e;
    logic [3:0] t;
    m = x[15] ? (~x + 16'h0001) : x;
    if (alaw) m = m >> 3;
    else m = ((m >> 2) + 16'h0021) >> 1;
    if (m > 16'h0fff) m = 16'h0fff;
    e = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (m[i + 4]) e = 3'(i);
    end
    t = 4'(m >> ((alaw && e == 3'h0) ? 3'h1 : e));
    if (alaw) return {~x[15], e, t} ^ 8'h55;
    return ~{x[15], e, t};
  endfunction

  function automatic logic [15:0] f_exp(input logic [7:0] c, input logic alaw);
    logic [7:0] d;
    logic [15:0] m;
    logic neg;
    d = alaw ? (c ^ 8'h55) : ~c;
    if (alaw) begin
      m = {8'h00, d[3:0], 4'h8};
      if (d[6:4] != 3'h0) m = (m + 16'h0100) << (d[6:4] - 3'h1);
      neg = ~d[7];
    end else begin
      m = (({9'h000, d[3:0], 3'h0} + 16'h0084) << d[6:4]) - 16'h0084;
      neg = d[7];
    end
    return neg ? (~m + 16'h0001) : m;
  endfunction

  always_comb begin
    logic [31:0] c;
    logic [31:0] w;
    logic [31:0] r;
    logic [31:0] rd;
    logic [31:0] srcv;
    logic [31:0] oev;
    logic [5:0] wl;
    logic [7:0] hp;
    logic [NLINE-1:0] clr;
    logic [6:0] a;
    asp_mode_type md;
    logic ckv;
    logic fsv;
    logic rise;
    logic fall;
    logic ev;
    logic st;
    logic tx;
    logic b;
    logic lsbf;
    logic wr;
    int q;
    int k;
    int sel;
    int ix;
    c = '0;
    w = '0;
    r = '0;
    rd = '0;
    srcv = '0;
    oev = '0;
    wl = '0;
    hp = '0;
    clr = '0;
    a = AVS_ADDRESS_IN;
    md = MODE_STD;
    ckv = 1'b0;
    fsv = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    ev = 1'b0;
    st = 1'b0;
    tx = 1'b0;
    b = 1'b0;
    lsbf = 1'b0;
    wr = 1'b0;
    q = 0;
    k = 0;
    sel = -1;
    ix = 0;
    n = s;
    n.ps1 = APP_PINS_IN;
    n.ps2 = s.ps1;
    n.gs1 = {l.fs, l.ck};
    n.gs2 = s.gs1;
    wr = AVS_WRITE_IN && !s.wrq;
    if (wr && a == OFS_STAT) clr = AVS_WRITEDATA_IN[ST_ERR +: NLINE];
    for (int i = 0; i < NLINE; i++) begin
      n.line[i].err = s.line[i].err & ~clr[i];
    end

    // dma: one access at a time, lowest line first
    if (s.mem.req) begin
      if (MEM_ACK_IN) begin
        n.mem.req = 1'b0;
        if (!s.mem.we) begin
          n.line[s.mem.sel].data = MEM_RDATA_IN;
          n.line[s.mem.sel].full = 1'b1;
        end
      end
    end else begin
      for (int i = NLINE - 1; i >= 0; i--) begin
        tx = s.ctl[i/2][CTL_DIR + i%2];
        if (s.ctl[i/2][CTL_EN] && (tx ? !s.line[i].full : s.line[i].full)) sel = i;
      end
      if (sel >= 0) begin
        tx = s.ctl[sel/2][CTL_DIR + sel%2];
        n.mem.req = 1'b1;
        n.mem.we = ~tx;
        n.mem.addr = s.line[sel].addr;
        n.mem.wdata = s.line[sel].data;
        n.mem.sel = 4'(sel);
        n.line[sel].addr = s.line[sel].addr + AW'(1);
        if (!tx) n.line[sel].full = 1'b0;
      end
    end

    for (int p = 0; p < NPORT; p++) begin
      c = s.ctl[p];
      q = c[CTL_PAIR] ? (p ^ 1) : p;
      md = asp_mode_type'(c[CTL_MODE +: 2]);
      lsbf = c[CTL_LSBF];
      wl = {1'b0, c[CTL_WLEN +: 5]} + 6'h01;
      if (wl < WL_MIN) wl = WL_MIN;
      if (md inside {MODE_I2S, MODE_LJ} && wl < WL_MIN_LR) wl = WL_MIN_LR;
      hp = s.div[p][DV_HALF +: 8];
      if (hp < DIV_MIN) hp = DIV_MIN;
      if (c[CTL_EN] && c[CTL_CKI]) begin
        n.port[p].div = s.port[p].div + 8'h01;
        if (s.port[p].div >= hp - 8'h01) begin
          n.port[p].div = '0;
          n.port[p].ck = ~s.port[p].ck;
        end
      end else begin
        n.port[p].div = '0;
        n.port[p].ck = 1'b0;
      end
      // partner's own clock is used unsynchronised, pins go through the synchroniser
      ckv = s.ctl[q][CTL_CKI] ? s.port[q].ck : f_pick(s.insel[q][IN_CK +: 5], s.ps2, s.gs2);
      fsv = s.ctl[q][CTL_FSI] ? s.port[q].fs : f_pick(s.insel[q][IN_FS +: 5], s.ps2, s.gs2);
      rise = ckv & ~s.port[p].ckp;
      fall = ~ckv & s.port[p].ckp;
      n.port[p].ckp = ckv;
      if (!c[CTL_EN]) begin
        n.port[p].bits = '0;
        n.port[p].arm = 1'b0;
        n.port[p].slot = '0;
        n.port[p].fs = 1'b0;
        n.port[p].txd = '0;
      end
      // internal sync moves on rising edges so it is seen at the next falling edge
      if (c[CTL_EN] && c[CTL_FSI] && rise) begin
        n.port[p].fcnt = s.port[p].fcnt - 8'h01;
        if (s.port[p].fcnt == 8'h00) begin
          n.port[p].fcnt = s.div[p][DV_FRM +: 8];
          n.port[p].fs = (md inside {MODE_I2S, MODE_LJ}) ? ~s.port[p].fs : 1'b1;
        end else if (!(md inside {MODE_I2S, MODE_LJ})) begin
          n.port[p].fs = 1'b0;
        end
      end
      if (c[CTL_EN] && fall) begin
        ev = (md inside {MODE_I2S, MODE_LJ}) ? (fsv ^ s.port[p].fsp)
                                              : (fsv & ~s.port[p].fsp);
        n.port[p].fsp = fsv;
        n.port[p].arm = (md == MODE_I2S) && ev; // i2s starts one bit late
        st = (md == MODE_I2S) ? s.port[p].arm : ev;
        if (st) n.port[p].slot = c[CTL_SLOT +: 7];
        else if (md == MODE_TDM && s.port[p].bits == '0 && s.port[p].slot != '0) begin
          st = 1'b1;
          n.port[p].slot = s.port[p].slot - 7'h01;
        end
        if (st) n.port[p].bits = wl;
        for (int i = 0; i < 2; i++) begin
          k = 2 * p + i;
          tx = c[CTL_DIR + i];
          if (st && tx) begin
            w = s.line[k].full ? s.line[k].data : '0;
            if (s.line[k].full) n.line[k].full = 1'b0;
            else n.line[k].err = 1'b1;
            if (c[CTL_CMP + i]) w = {24'h000000, f_cmp(w[15:0], c[CTL_ALAW])};
            n.port[p].tsh[i] = lsbf ? w : (w << (6'h20 - wl));
          end else if (s.port[p].bits != '0) begin
            n.port[p].tsh[i] = lsbf ? (s.port[p].tsh[i] >> 1) : (s.port[p].tsh[i] << 1);
          end
          n.port[p].txd[i] = tx & (lsbf ? n.port[p].tsh[i][0] : n.port[p].tsh[i][31]);
        end
      end
      if (c[CTL_EN] && rise && s.port[p].bits != '0) begin
        n.port[p].bits = s.port[p].bits - 6'h01;
        for (int i = 0; i < 2; i++) begin
          k = 2 * p + i;
          if (!c[CTL_DIR + i]) begin
            b = f_pick(s.insel[p][IN_D + 5*i +: 5], s.ps2, s.gs2);
            r = lsbf ? {b, s.port[p].rsh[i][31:1]} : {s.port[p].rsh[i][30:0], b};
            n.port[p].rsh[i] = r;
            if (s.port[p].bits == 6'h01) begin
              w = lsbf ? (r >> (6'h20 - wl)) : (r & (32'hffffffff >> (6'h20 - wl)));
              if (c[CTL_CMP + i]) begin
                w[15:0] = f_exp(w[7:0], c[CTL_ALAW]);
                w[31:16] = {16{w[15]}};
              end
              if (n.line[k].full) n.line[k].err = 1'b1; // overrun, new word kept
              n.line[k].data = w;
              n.line[k].full = 1'b1;
            end
          end
        end
      end
    end

    // register bus: answer one cycle after the request is seen
    n.wrq = !((AVS_READ_IN || AVS_WRITE_IN) && s.wrq);
    if (a >= OFS_INSEL && a < OFS_INSEL + 7'(NPORT)) begin
      ix = int'(a - OFS_INSEL);
      rd = {12'h000, s.insel[ix]};
      if (wr) n.insel[ix] = 20'(f_be(rd, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
    end else if (a >= OFS_ROUTE && a < OFS_ROUTE + 7'(NPIN)) begin
      ix = int'(a - OFS_ROUTE);
      rd = {22'h000000, s.route[ix]};
      if (wr) n.route[ix] = 10'(f_be(rd, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
    end else if (a >= OFS_DMA && a < OFS_DMA + 7'(NLINE)) begin
      ix = int'(a - OFS_DMA);
      rd = 32'(s.line[ix].addr);
      if (wr) n.line[ix].addr = AW'(f_be(rd, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
    end else if (a >= OFS_DIV && a < OFS_DIV + 7'(NPORT)) begin
      ix = int'(a - OFS_DIV);
      rd = {16'h0000, s.div[ix]};
      if (wr) n.div[ix] = 16'(f_be(rd, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
    end else if (a < OFS_CTL + 7'(NPORT)) begin
      ix = int'(a - OFS_CTL);
      rd = s.ctl[ix];
      if (wr) n.ctl[ix] = f_be(rd, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    end else if (a == OFS_PULL) begin
      rd = {12'h000, s.pull};
      if (wr) n.pull = 20'(f_be(rd, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN));
    end else if (a == OFS_GEN) begin
      rd = s.gen;
      if (wr) begin
        n.gen = f_be(rd, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        n.gtog = ~s.gtog;
      end
    end else if (a == OFS_STAT) begin
      for (int i = 0; i < NLINE; i++) begin
        rd[ST_ERR + i] = s.line[i].err;
        rd[ST_FULL + i] = s.line[i].full;
      end
      for (int p = 0; p < NPORT; p++) begin
        rd[ST_BUSY + p] = s.port[p].bits != '0;
      end
    end
    if (AVS_READ_IN && s.wrq) n.rdata = rd;

    // routing matrix sources and enable sources
    srcv[1:0] = 2'b10;
    oev[1:0] = 2'b10;
    for (int p = 0; p < NPORT; p++) begin
      srcv[2 + p] = s.port[p].ck;
      srcv[8 + p] = s.port[p].fs;
      oev[2 + p] = s.ctl[p][CTL_EN] & s.ctl[p][CTL_CKI];
      oev[8 + p] = s.ctl[p][CTL_EN] & s.ctl[p][CTL_FSI];
      for (int i = 0; i < 2; i++) begin
        srcv[14 + 2*p + i] = s.port[p].txd[i];
        oev[14 + 2*p + i] = s.ctl[p][CTL_EN] & s.ctl[p][CTL_DIR + i];
      end
    end
    srcv[27:26] = s.gs2;
    oev[27:26] = 2'b11;
    for (int i = 0; i < NPIN; i++) begin
      n.pout[i] = srcv[s.route[i][RT_SIG +: 5]];
      n.poe_n[i] = ~oev[s.route[i][RT_OE +: 5]];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s <= '0;
      s.pull <= PULL_RST;
      s.wrq <= 1'b1;
      s.poe_n <= '1;
    end else begin
      s <= n;
    end
  end

  // generator on the link clock; settings follow a toggle from the core side
  always_comb begin
    ln = l;
    ln.t1 = s.gtog;
    ln.t2 = l.t1;
    ln.t3 = l.t2;
    if (l.t2 != l.t3) ln.cfg = s.gen;
    ln.cnt = l.cnt + 16'h0001;
    if (l.cnt >= l.cfg[GN_HALF +: 16]) begin
      ln.cnt = '0;
      ln.ck = ~l.ck;
      if (!l.ck) begin
        ln.fcnt = l.fcnt - 16'h0001;
        if (l.fcnt == 16'h0000) begin
          ln.fcnt = l.cfg[GN_FRM +: 16];
          ln.fs = ~l.fs;
        end
      end
    end
  end

  always_ff @(posedge CLK_LINK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) l <= '0;
    else l <= ln;
  end

  assign AVS_READDATA_OUT = s.rdata;
  assign AVS_WAITREQUEST_OUT = s.wrq;
  assign APP_PINS_OUT = s.pout;
  assign APP_PINS_OE_N_OUT = s.poe_n;
  assign PIN_PULLUP_EN_OUT = s.pull;
  assign MEM_REQ_OUT = s.mem.req;
  assign MEM_WE_OUT = s.mem.we;
  assign MEM_ADDR_OUT = s.mem.addr;
  assign MEM_WDATA_OUT = s.mem.wdata;
endmodule

// ---- dv/asp_codec_model.sv ----
// Purpose: far-side codec acting as bit clock and frame sync master
// Assumes: clock derived from a free counter, never faster than core/4
// Notes: lines are released while disabled so the pin pull-ups decide them
`timescale 1ns/1ps
module asp_codec_model #(
  parameter int HALF = 4
) (
  input wire logic clk_in, // reference clock
  input wire logic rst_n_in, // reset, active low
  input wire logic en_in, // frames run while high
  input wire logic level_in, // sync is a level per half frame
  input wire logic [5:0] len_in, // bits per frame or half frame
  output logic [1:0] drv_out, // {sync, bit clock}
  output logic oe_out // high while driving
);
  logic [7:0] cnt_q;
  logic [5:0] pos_q;
  logic sclk_q;
  logic fs_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in || !en_in) begin
      cnt_q <= 8'h00;
      pos_q <= 6'h00;
      sclk_q <= 1'b0;
      fs_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 8'(HALF - 1)) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q == 8'(HALF - 1)) begin
        sclk_q <= ~sclk_q;
        // sync moves only on the falling bit clock edge
        if (sclk_q) begin
          pos_q <= (pos_q == len_in - 6'h01) ? 6'h00 : pos_q + 6'h01;
          if (pos_q == len_in - 6'h01) fs_q <= level_in ? ~fs_q : 1'b1;
          else if (!level_in) fs_q <= 1'b0;
        end
      end
    end
  end
  assign drv_out = {fs_q, sclk_q};
  assign oe_out = en_in;
endmodule

// ---- dv/asp_monitor.sv ----
// Purpose: concurrent checks on the register bus, pins and dma port
// Assumes: single core clock domain for everything watched here
// Notes: route checks watch pin 8 only, the bench exercises that pin
`timescale 1ns/1ps
module asp_monitor
  import asp_pkg::*;
(
  input wire logic CLK_SYS_IN, // core clock
  input wire logic RESETN_IN, // reset, active low
  input wire logic [6:0] AVS_ADDRESS_IN, // word address
  input wire logic AVS_READ_IN, // read
  input wire logic AVS_WRITE_IN, // write
  input wire logic [31:0] AVS_WRITEDATA_IN, // write data
  input wire logic [3:0] AVS_BYTEENABLE_IN, // byte lanes
  input wire logic [31:0] AVS_READDATA_OUT, // read data
  input wire logic AVS_WAITREQUEST_OUT, // stall
  input wire logic [NPIN-1:0] APP_PINS_OUT, // pin drive
  input wire logic [NPIN-1:0] APP_PINS_OE_N_OUT, // pin enables
  input wire logic [NPIN-1:0] PIN_PULLUP_EN_OUT, // pull-ups
  input wire logic MEM_REQ_OUT, // dma request
  input wire logic MEM_WE_OUT, // dma write
  input wire logic [AW-1:0] MEM_ADDR_OUT, // dma address
  input wire logic MEM_ACK_IN // dma done
);
  logic [NPIN-1:0] pw_q;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence s_req; (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT; endsequence
  sequence s_ans; !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT; endsequence
  sequence s_rd; AVS_READ_IN && !AVS_WAITREQUEST_OUT; endsequence
  sequence s_wr(a);
    AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN == 4'hf && AVS_ADDRESS_IN == a;
  endsequence
  // remembers the last pull-up write whatever its byte lanes, output may lag by a register
  always_ff @(posedge CLK_SYS_IN) begin
    if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == OFS_PULL) begin
      pw_q <= AVS_WRITEDATA_IN[NPIN-1:0];
    end
  end
  property p_answer; s_req |=> s_ans; endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  property p_wait_one; $fell(AVS_WAITREQUEST_OUT) |=> AVS_WAITREQUEST_OUT; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_pull_reset; $rose(RESETN_IN) |-> PIN_PULLUP_EN_OUT == PULL_RST; endproperty
  a_pull_reset: assert property (p_pull_reset) else $error("pull-ups off at reset");
  property p_pull_write; s_wr(OFS_PULL) |-> ##2 PIN_PULLUP_EN_OUT == pw_q; endproperty
  a_pull_write: assert property (p_pull_write) else $error("pull-up write lost");
  property p_readback;
    s_rd and AVS_ADDRESS_IN == OFS_PULL |-> AVS_READDATA_OUT == {12'h000, PIN_PULLUP_EN_OUT};
  endproperty
  a_readback: assert property (p_readback) else $error("pull-up readback wrong");
  property p_unmapped; s_rd and AVS_ADDRESS_IN == 7'h7f |-> AVS_READDATA_OUT == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_route_on;
    s_wr(7'(OFS_ROUTE + 7'h08)) and AVS_WRITEDATA_IN[9:0] == 10'h021
      |-> ##[1:3] (APP_PINS_OUT[8] && !APP_PINS_OE_N_OUT[8]);
  endproperty
  a_route_on: assert property (p_route_on) else $error("routed constant not driven");
  property p_route_off;
    s_wr(7'(OFS_ROUTE + 7'h08)) and AVS_WRITEDATA_IN[9:5] == 5'h00 |-> ##[1:3] APP_PINS_OE_N_OUT[8];
  endproperty
  a_route_off: assert property (p_route_off) else $error("pin driven with no enable");
  property p_mem_hold;
    MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT) && $stable(MEM_WE_OUT);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("dma request dropped early");
endmodule
bind asp_top asp_monitor u_mon (.CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN),
  .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
  .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .APP_PINS_OUT(APP_PINS_OUT), .APP_PINS_OE_N_OUT(APP_PINS_OE_N_OUT),
  .PIN_PULLUP_EN_OUT(PIN_PULLUP_EN_OUT), .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_WE_OUT(MEM_WE_OUT),
  .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_ACK_IN(MEM_ACK_IN));

// ---- dv/asp_top_tb_top.sv ----
// Purpose: self-checking bench for the audio serial port array
// Assumes: codec model drives bit clock on pin 4 and sync on pin 5
// Notes: port0 line0 sends to port1 line0 over pin 7, so bit order is not observable
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module asp_top_tb_top;
  import asp_pkg::*;
  logic clk, clk_link, rst_n, rd, wr, wait_out, mem_req, mem_we;
  logic mem_ack = 1'b0;
  logic tgl = 1'b0;
  logic cod_en, cod_lvl, cod_oe, last;
  logic [6:0] addr;
  logic [3:0] be;
  logic [5:0] wl, cod_len;
  logic [1:0] cod_drv;
  logic [31:0] wdata, rdata, mem_wdata, dval, ctl, r, er;
  logic [31:0] mem_rdata = 32'h0;
  logic [47:0] em;
  logic [AW-1:0] mem_addr;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe_n, pull_en;
  logic [31:0] exp_rd[$];
  logic [47:0] exp_mem[$];
  logic [9:0] rt[3] = '{10'h021, 10'h020, 10'h001};
  logic [1:0] ex[3] = '{2'b10, 2'b00, 2'b11};
  int err_total, comparisons, n, cnt;

  asp_top uut (.CLK_SYS_IN(clk), .CLK_LINK_IN(clk_link), .RESETN_IN(rst_n),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_out),
    .APP_PINS_IN(pin_in), .APP_PINS_OUT(pin_out), .APP_PINS_OE_N_OUT(pin_oe_n),
    .PIN_PULLUP_EN_OUT(pull_en), .MEM_REQ_OUT(mem_req), .MEM_WE_OUT(mem_we),
    .MEM_ADDR_OUT(mem_addr), .MEM_WDATA_OUT(mem_wdata), .MEM_ACK_IN(mem_ack),
    .MEM_RDATA_IN(mem_rdata));
  asp_codec_model #(.HALF(4)) u_codec (.clk_in(clk), .rst_n_in(rst_n), .en_in(cod_en),
    .level_in(cod_lvl), .len_in(cod_len), .drv_out(cod_drv), .oe_out(cod_oe));

  // wire level: device, then codec, then pull-up, else a pattern that never settles
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (cod_oe && (i == 4 || i == 5)) pin_in[i] = cod_drv[i-4];
      else pin_in[i] = pull_en[i] | tgl;
    end
  end
  // memory answers one cycle late; read data is junk outside the ack
  always @(posedge clk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= (mem_req && !mem_ack) ? dval : ~dval;
    tgl <= ~tgl;
  end
  always @(posedge clk) begin
    if (rd && wait_out === 1'b0 && exp_rd.size() > 0) begin
      er = exp_rd.pop_front();
      `CHK(rdata, er)
    end
    if (mem_ack && mem_we && exp_mem.size() > 0) begin
      em = exp_mem.pop_front();
      `CHK({mem_addr, mem_wdata}, em)
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    clk_link = 1'b0;
    #3;
    forever #6 clk_link = ~clk_link;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    finish_test();
  end

  task automatic bus(input logic we, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= we;
    rd <= !we;
    wdata <= d;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (wait_out !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {rst_n, rd, wr, cod_en, cod_lvl} = '0;
    {addr, wdata, cod_len} = '0;
    be = 4'hf;
    err_total = 0;
    comparisons = 0;
    dval = $urandom(32'h55b00987);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    `CHK(pull_en, PULL_RST)
    `CHK(pin_oe_n, 20'hfffff)
    rchk(OFS_PULL, 32'(PULL_RST));
    r = $urandom();
    bus(1'b1, OFS_PULL, r);
    rchk(OFS_PULL, {12'h000, r[19:0]});
    `CHK(pull_en, r[19:0])
    bus(1'b1, OFS_PULL, 32'(PULL_RST));
    bus(1'b1, 7'h7f, r);
    rchk(7'h7f, 32'h0);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 7'(OFS_ROUTE + 7'h08), {22'h0, rt[k]});
      repeat (3) @(posedge clk);
      `CHK({pin_out[8], pin_oe_n[8]}, ex[k])
    end
    // generator half period of 4 link cycles is 48 ns, seen through 40 ns sampling
    bus(1'b1, OFS_GEN, 32'h0000_0003);
    bus(1'b1, 7'(OFS_ROUTE + 7'h03), {22'h0, 5'h1a, 5'h1a});
    repeat (20) @(posedge clk);
    cnt = 0;
    last = pin_out[3];
    repeat (100) begin
      @(posedge clk);
      if (pin_out[3] !== last) cnt++;
      last = pin_out[3];
    end
    `CHK(cnt >= 82 && cnt <= 85, 1'b1)
    // internal bit clock at the minimum half period of two core cycles
    bus(1'b1, 7'(OFS_CTL + 7'h02), 32'h0000_0201);
    bus(1'b1, 7'(OFS_ROUTE + 7'h09), {22'h0, 5'h04, 5'h04});
    repeat (4) @(posedge clk);
    `CHK(pin_oe_n[9], 1'b0)
    cnt = 0;
    last = pin_out[9];
    repeat (40) begin
      @(posedge clk);
      if (pin_out[9] !== last) cnt++;
      last = pin_out[9];
    end
    `CHK(cnt, 20)
    bus(1'b1, 7'(OFS_CTL + 7'h02), 32'h0);
    bus(1'b1, OFS_INSEL, {22'h0, 5'h05, 5'h04});
    bus(1'b1, 7'(OFS_INSEL + 7'h01), {12'h0, 5'h00, 5'h07, 10'h000});
    bus(1'b1, 7'(OFS_ROUTE + 7'h07), {22'h0, 5'h0e, 5'h0e});
    for (int m = 0; m < 4; m++) begin
      wl = 6'h08 + 6'($urandom % 9);
      // tx buffers keep their word across runs, so the memory word stays fixed
      bus(1'b1, OFS_DMA, 32'h200);
      bus(1'b1, 7'(OFS_DMA + 7'h02), 32'h100);
      ctl = 32'h1 | (32'(m) << 1) | (32'(m % 2) << 3) | (32'(wl - 6'h01) << 4);
      // lines 0, 1 and 3 transmit, so line 2 is the only one writing memory
      bus(1'b1, OFS_CTL, ctl | 32'h1800);
      bus(1'b1, 7'(OFS_CTL + 7'h01), ctl | 32'h11000);
      cod_lvl <= (m >= 2);
      cod_len <= (m >= 2) ? wl + 6'h02 : wl + 6'h04;
      repeat (30) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        exp_mem.push_back({16'(16'h100 + 16'(k)), dval & ((32'h1 << wl) - 32'h1)});
      end
      cod_en <= 1'b1;
      n = 0;
      while (exp_mem.size() > 0 && n < 4000) begin
        @(posedge clk);
        n++;
      end
      `CHK(32'(exp_mem.size()), 32'h0)
      cod_en <= 1'b0;
      bus(1'b1, OFS_CTL, 32'h0);
      bus(1'b1, 7'(OFS_CTL + 7'h01), 32'h0);
      exp_mem.delete();
      repeat (40) @(posedge clk);
    end
    finish_test();
  end
endmodule
